/* hw/eac_pkg.sv */
package eac_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned TIMER_W         = 18;
  localparam int unsigned EE_ERASE_NS     = 1000;
  localparam int unsigned EE_PROG_NS      = 1000;
  localparam int unsigned FLASH_OP_NS     = 2000000;
  localparam int unsigned EE_ERASE_CYCLES = ns_to_cycles(EE_ERASE_NS);
  localparam int unsigned EE_PROG_CYCLES  = ns_to_cycles(EE_PROG_NS);
  localparam logic [TIMER_W-1:0] EE_ERASE_LOAD = TIMER_W'(EE_ERASE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] EE_PROG_LOAD  = TIMER_W'(EE_PROG_CYCLES - 1);

  localparam logic [3:0] OFF_TBL_UPPER = 4'h0;
  localparam logic [3:0] OFF_TBL_HIGH  = 4'h1;
  localparam logic [3:0] OFF_TBL_LOW   = 4'h2;
  localparam logic [3:0] OFF_TBL_LATCH = 4'h3;
  localparam logic [3:0] OFF_KEY       = 4'h4;
  localparam logic [3:0] OFF_CONTROL   = 4'h5;
  localparam logic [3:0] OFF_EE_DATA   = 4'h6;
  localparam logic [3:0] OFF_EE_ADDR   = 4'h7;
  localparam logic [3:0] OFF_FLAGS     = 4'h8;

  localparam int unsigned CTL_SPACE     = 7;
  localparam int unsigned CTL_CFG       = 6;
  localparam int unsigned CTL_ROW_ERASE = 4;
  localparam int unsigned CTL_ABORT     = 3;
  localparam int unsigned CTL_GATE      = 2;
  localparam int unsigned CTL_WR        = 1;
  localparam int unsigned CTL_RD        = 0;
  localparam int unsigned FLAG_WR_DONE  = 0;

  localparam logic [7:0] KEY_FIRST     = 8'h55;
  localparam logic [7:0] KEY_SECOND    = 8'hAA;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [5:0] RST_TBL_UPPER = 6'h00;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam int unsigned EE_DEPTH     = 256;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b11,
    ST_FLASH = 2'b10
  } eac_state_t;

  typedef enum logic [1:0] {
    KEY_IDLE      = 2'b00,
    KEY_GOT_FIRST = 2'b01,
    KEY_ARMED     = 2'b11
  } eac_key_t;

  typedef enum logic [1:0] {
    CAUSE_POWER_ON  = 2'b00,
    CAUSE_BROWN_OUT = 2'b01,
    CAUSE_EXT_PIN   = 2'b10,
    CAUSE_WATCHDOG  = 2'b11
  } eac_cause_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eac_bus_req_t;

  typedef struct packed {
    logic        erase;
    logic        prog;
    logic        cfg;
    logic [21:0] addr;
  } eac_flash_cmd_t;

endpackage

/* hw/eac_ctrl.sv */
// The plain strobed port and the register offsets are this design's own decisions.
module eac_ctrl
  import eac_pkg::*;
#(
  parameter int unsigned FLASH_OP_CYCLES = ns_to_cycles(FLASH_OP_NS),
  parameter logic [7:0]  CFG_READ_VALUE  = 8'h00
) (
  input  wire logic     clock,
  input  wire logic     rst,
  input  eac_cause_t    reset_cause,
  input  wire logic     pwrt_running,
  input  eac_bus_req_t  bus,
  output logic [7:0]    rdata,
  output logic          write_complete_flag,
  output logic          cpu_stall,
  output eac_flash_cmd_t flash_cmd
);

  localparam logic [TIMER_W-1:0] FLASH_LOAD = TIMER_W'(FLASH_OP_CYCLES - 1);
  localparam int A_ERASE = EE_ERASE_CYCLES;
  localparam int A_PROG  = EE_PROG_CYCLES;

  logic [7:0]         mem [EE_DEPTH];
  logic [5:0]         tbl_u_reg;
  logic [7:0]         tbl_h_reg;
  logic [7:0]         tbl_l_reg;
  logic [7:0]         latch_reg;
  logic               space_reg;
  logic               cfg_reg;
  logic               row_erase_reg;
  logic               abort_reg;
  logic               gate_reg;
  logic               wr_reg;
  logic               rd_reg;
  logic [7:0]         data_reg;
  logic [7:0]         addr_reg;
  logic               flag_reg;
  logic [7:0]         rdata_reg;
  logic               stall_reg;
  eac_flash_cmd_t     cmd_reg;
  eac_state_t         state_reg;
  eac_state_t         state_next;
  eac_key_t           key_reg;
  eac_key_t           key_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;

  wire wr_hit_ctl   = bus.wr && (bus.addr == OFF_CONTROL);
  wire wr_hit_key   = bus.wr && (bus.addr == OFF_KEY);
  wire wr_hit_data  = bus.wr && (bus.addr == OFF_EE_DATA);
  wire wr_hit_addr  = bus.wr && (bus.addr == OFF_EE_ADDR);
  wire wr_hit_flags = bus.wr && (bus.addr == OFF_FLAGS);
  wire busy         = (state_reg != ST_IDLE);
  wire timer_done   = (timer_reg == '0);
  wire erase_done   = (state_reg == ST_ERASE) && timer_done;
  wire ee_done      = (state_reg == ST_PROG) && timer_done;
  wire flash_done   = (state_reg == ST_FLASH) && timer_done;
  wire op_done      = ee_done || flash_done;
  wire ctl_take     = wr_hit_ctl && !busy;
  // Old gate value is used, so gate and start in one write fail
  wire wr_start_ok  = ctl_take && bus.wdata[CTL_WR] && (key_reg == KEY_ARMED) && gate_reg && !pwrt_running;
  wire rd_start_ok  = ctl_take && bus.wdata[CTL_RD] && !bus.wdata[CTL_SPACE];
  wire flash_space  = bus.wdata[CTL_SPACE] || bus.wdata[CTL_CFG];
  wire por_like     = (reset_cause == CAUSE_POWER_ON) || (reset_cause == CAUSE_BROWN_OUT);
  wire cut_reset    = busy && ((reset_cause == CAUSE_EXT_PIN) || (reset_cause == CAUSE_WATCHDOG));
  wire abort_rst    = cut_reset ? 1'b1 : (por_like ? 1'b0 : abort_reg);
  wire wr_next      = wr_start_ok ? 1'b1 : (op_done ? 1'b0 : wr_reg);
  wire flag_next    = op_done || (flag_reg && !(wr_hit_flags && !bus.wdata[FLAG_WR_DONE]));
  wire [7:0] ctl_view = {space_reg, cfg_reg, 1'b0, row_erase_reg, abort_reg, gate_reg, wr_reg, rd_reg};
  wire [7:0] rd_mux =
    (bus.addr == OFF_TBL_UPPER) ? {2'b00, tbl_u_reg} :
    (bus.addr == OFF_TBL_HIGH)  ? tbl_h_reg :
    (bus.addr == OFF_TBL_LOW)   ? tbl_l_reg :
    (bus.addr == OFF_TBL_LATCH) ? latch_reg :
    (bus.addr == OFF_CONTROL)   ? ctl_view :
    (bus.addr == OFF_EE_DATA)   ? data_reg :
    (bus.addr == OFF_EE_ADDR)   ? addr_reg :
    (bus.addr == OFF_FLAGS)     ? {7'h00, flag_reg} : 8'h00;

  // Unlock tracker: any access other than the next key step or a fresh 55h key write drops it
  always_comb begin
    key_next = key_reg;
    if (wr_hit_key && (bus.wdata == KEY_FIRST)) begin
      key_next = KEY_GOT_FIRST;
    end else if (wr_hit_key && (bus.wdata == KEY_SECOND) && (key_reg == KEY_GOT_FIRST)) begin
      key_next = KEY_ARMED;
    end else if (bus.wr || bus.rd) begin
      key_next = KEY_IDLE;
    end
  end

  always_comb begin
    state_next = state_reg;
    timer_next = (busy && !timer_done) ? TIMER_W'(timer_reg - 1'b1) : timer_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wr_start_ok) begin
          state_next = flash_space ? ST_FLASH : ST_ERASE;
          timer_next = flash_space ? FLASH_LOAD : EE_ERASE_LOAD;
        end
      end
      ST_ERASE: begin
        if (timer_done) begin
          state_next = ST_PROG;
          timer_next = EE_PROG_LOAD;
        end
      end
      ST_PROG: begin
        if (timer_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_FLASH: begin
        if (timer_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      key_reg   <= KEY_IDLE;
      stall_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      key_reg   <= key_next;
      stall_reg <= (state_next == ST_FLASH);
    end
  end

  // Array keeps its content through reset; a cut write may leave FFh
  always_ff @(posedge clock) begin
    if (!rst && erase_done) begin
      mem[addr_reg] <= ERASED_BYTE;
    end else if (!rst && ee_done) begin
      mem[addr_reg] <= data_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      space_reg     <= por_like ? 1'b0 : space_reg;
      cfg_reg       <= por_like ? 1'b0 : cfg_reg;
      row_erase_reg <= por_like ? 1'b0 : row_erase_reg;
      abort_reg     <= abort_rst;
      gate_reg      <= 1'b0;
      wr_reg        <= 1'b0;
      rd_reg        <= 1'b0;
    end else begin
      space_reg     <= ctl_take ? bus.wdata[CTL_SPACE] : space_reg;
      cfg_reg       <= ctl_take ? bus.wdata[CTL_CFG] : cfg_reg;
      row_erase_reg <= ctl_take ? bus.wdata[CTL_ROW_ERASE] :
                       ((flash_done && cmd_reg.erase) ? 1'b0 : row_erase_reg);
      abort_reg     <= ctl_take ? bus.wdata[CTL_ABORT] : (op_done ? 1'b0 : abort_reg);
      // Gate stays writable while busy, so firmware can drop it early
      gate_reg      <= wr_hit_ctl ? bus.wdata[CTL_GATE] : gate_reg;
      wr_reg        <= wr_next;
      rd_reg        <= rd_start_ok;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_reg <= RST_BYTE;
      addr_reg <= RST_BYTE;
    end else begin
      if (rd_reg) begin
        data_reg <= cfg_reg ? CFG_READ_VALUE : mem[addr_reg];
      end else if (wr_hit_data && !busy) begin
        data_reg <= bus.wdata;
      end
      addr_reg <= (wr_hit_addr && !busy) ? bus.wdata : addr_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tbl_u_reg <= RST_TBL_UPPER;
      tbl_h_reg <= RST_BYTE;
      tbl_l_reg <= RST_BYTE;
      latch_reg <= RST_BYTE;
      flag_reg  <= 1'b0;
      rdata_reg <= RST_BYTE;
      cmd_reg   <= '0;
    end else begin
      tbl_u_reg <= (bus.wr && bus.addr == OFF_TBL_UPPER) ? bus.wdata[5:0] : tbl_u_reg;
      tbl_h_reg <= (bus.wr && bus.addr == OFF_TBL_HIGH) ? bus.wdata : tbl_h_reg;
      tbl_l_reg <= (bus.wr && bus.addr == OFF_TBL_LOW) ? bus.wdata : tbl_l_reg;
      latch_reg <= (bus.wr && bus.addr == OFF_TBL_LATCH) ? bus.wdata : latch_reg;
      flag_reg  <= flag_next;
      rdata_reg <= bus.rd ? rd_mux : RST_BYTE;
      if (wr_start_ok && flash_space) begin
        cmd_reg <= '{erase: bus.wdata[CTL_ROW_ERASE], prog: !bus.wdata[CTL_ROW_ERASE],
                     cfg: bus.wdata[CTL_CFG], addr: {tbl_u_reg, tbl_h_reg, tbl_l_reg}};
      end else if (flash_done) begin
        cmd_reg <= '0;
      end
    end
  end

  assign rdata               = rdata_reg;
  assign write_complete_flag = flag_reg;
  assign cpu_stall           = stall_reg;
  assign flash_cmd           = cmd_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_unlock_order;
    $rose(wr_reg) |-> $past(key_reg) == KEY_ARMED;
  endproperty
  a_unlock_order: assert property (p_unlock_order) else $error("write started without unlock");

  property p_gate_prior;
    $rose(wr_reg) |-> $past(gate_reg) && !$past(pwrt_running);
  endproperty
  a_gate_prior: assert property (p_gate_prior) else $error("write started without prior gate");

  property p_key_reads_zero;
    bus.rd && (bus.addr == OFF_KEY) |=> rdata_reg == 8'h00;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key port read nonzero");

  property p_bit5_zero;
    bus.rd && (bus.addr == OFF_CONTROL) |=> !rdata_reg[5];
  endproperty
  a_bit5_zero: assert property (p_bit5_zero) else $error("control bit 5 read as one");

  property p_read_one_cycle;
    rd_reg |=> !rd_reg && data_reg == (cfg_reg ? CFG_READ_VALUE : mem[$past(addr_reg)]);
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read did not finish in one cycle");

  property p_read_not_flash;
    $rose(rd_reg) |-> !space_reg;
  endproperty
  a_read_not_flash: assert property (p_read_not_flash) else $error("read started in flash space");

  property p_erase_length;
    $rose(state_reg == ST_ERASE) |-> ##[A_ERASE:A_ERASE] (state_reg == ST_PROG) && mem[addr_reg] == ERASED_BYTE;
  endproperty
  a_erase_length: assert property (p_erase_length) else $error("erase phase length wrong");

  property p_prog_length;
    $rose(state_reg == ST_PROG) |-> ##[A_PROG:A_PROG] (state_reg == ST_IDLE) && flag_reg && !wr_reg;
  endproperty
  a_prog_length: assert property (p_prog_length) else $error("program phase length wrong");

  property p_prog_value;
    ee_done |=> mem[addr_reg] == data_reg;
  endproperty
  a_prog_value: assert property (p_prog_value) else $error("programmed byte mismatch");

  property p_locked_while_busy;
    busy && (wr_hit_data || wr_hit_addr) |=> $stable(data_reg) && $stable(addr_reg);
  endproperty
  a_locked_while_busy: assert property (p_locked_while_busy) else $error("registers changed while busy");

  property p_flag_sticky;
    flag_reg && !(wr_hit_flags && !bus.wdata[FLAG_WR_DONE]) |=> flag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without software");

  property p_unlock_drop;
    (key_reg != KEY_IDLE) && bus.rd |=> key_reg == KEY_IDLE;
  endproperty
  a_unlock_drop: assert property (p_unlock_drop) else $error("unlock survived stray access");

  property p_row_erase_clear;
    flash_done && cmd_reg.erase |=> !row_erase_reg && !cpu_stall;
  endproperty
  a_row_erase_clear: assert property (p_row_erase_clear) else $error("row erase bit not cleared");

  property p_abort_on_cut;
    @(posedge clock) disable iff (1'b0)
      rst && cut_reset |=> abort_reg && data_reg == RST_BYTE && addr_reg == RST_BYTE && space_reg == $past(space_reg);
  endproperty
  a_abort_on_cut: assert property (p_abort_on_cut) else $error("aborting reset handled wrongly");

  c_ee_write: cover property ($rose(state_reg == ST_ERASE));
  c_flash_op: cover property (flash_done);
  c_ee_read: cover property (rd_reg);
  c_abort: cover property (@(posedge clock) disable iff (1'b0) rst && cut_reset);

endmodule

/* tb/eac_tb.sv */
module testbench import eac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // Short flash timing keeps the run small
  localparam int unsigned FOC  = 20;
  localparam logic [7:0]  CFGV = 8'h5A;

  logic           clock        = 1'b0;
  logic           rst          = 1'b1;
  eac_cause_t     reset_cause  = CAUSE_POWER_ON;
  logic           pwrt_running = 1'b0;
  eac_bus_req_t   bus          = '0;
  logic [7:0]     rdata;
  logic           write_complete_flag;
  logic           cpu_stall;
  eac_flash_cmd_t flash_cmd;
  int             n_errors     = 0;
  int             n_compared   = 0;
  int             cyc          = 0;
  int             n;
  int             k;
  time            t0;
  logic [7:0]     v;

  eac_ctrl #(
    .FLASH_OP_CYCLES (FOC),
    .CFG_READ_VALUE  (CFGV)
  ) dut_u (
    .clock               (clock),
    .rst                 (rst),
    .reset_cause         (reset_cause),
    .pwrt_running        (pwrt_running),
    .bus                 (bus),
    .rdata               (rdata),
    .write_complete_flag (write_complete_flag),
    .cpu_stall           (cpu_stall),
    .flash_cmd           (flash_cmd)
  );

  always #5 clock = ~clock;

  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Leaves one idle cycle after each strobe so no edge sees two assignments
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    bus_rd(a, d);
    chk(nm, 32'(e), 32'(d));
  endtask

  task automatic unlock;
    bus_wr(OFF_KEY, KEY_FIRST);
    bus_wr(OFF_KEY, KEY_SECOND);
  endtask

  task automatic do_reset(input eac_cause_t c);
    @(posedge clock);
    rst         <= 1'b1;
    reset_cause <= c;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (k = 0; k < 16; k++) begin
      rchk(4'(k), 8'h00, "reset_value");
    end
    bus_wr(OFF_TBL_UPPER, 8'h2A);
    bus_wr(OFF_TBL_HIGH, 8'hC3);
    bus_wr(OFF_TBL_LOW, 8'h40);
    bus_wr(OFF_TBL_LATCH, 8'h5A);
    bus_wr(OFF_KEY, 8'h77);
    rchk(OFF_TBL_UPPER, 8'h2A, "tbl_upper");
    rchk(OFF_TBL_HIGH, 8'hC3, "tbl_high");
    rchk(OFF_TBL_LOW, 8'h40, "tbl_low");
    rchk(OFF_TBL_LATCH, 8'h5A, "tbl_latch");
    rchk(OFF_KEY, 8'h00, "key_port");
    bus_wr(OFF_CONTROL, 8'h20);
    rchk(OFF_CONTROL, 8'h00, "ctl_bit5");
    bus_wr(OFF_CONTROL, 8'h81);
    rchk(OFF_CONTROL, 8'h80, "rd_refused");
    bus_wr(OFF_CONTROL, 8'h41);
    rchk(OFF_EE_DATA, CFGV, "cfg_read");
    rchk(OFF_CONTROL, 8'h40, "rd_cleared");
    bus_wr(OFF_CONTROL, 8'h00);
    // Refused starts: no gate, gate in same write, broken keys, power-up timer
    unlock();
    bus_wr(OFF_CONTROL, 8'h02);
    rchk(OFF_CONTROL, 8'h00, "wr_no_gate");
    unlock();
    bus_wr(OFF_CONTROL, 8'h06);
    rchk(OFF_CONTROL, 8'h04, "gate_and_wr");
    bus_wr(OFF_KEY, KEY_FIRST);
    bus_rd(OFF_TBL_LOW, v);
    bus_wr(OFF_KEY, KEY_SECOND);
    bus_wr(OFF_CONTROL, 8'h06);
    rchk(OFF_CONTROL, 8'h04, "broken_unlock");
    @(posedge clock) pwrt_running <= 1'b1;
    unlock();
    bus_wr(OFF_CONTROL, 8'h06);
    rchk(OFF_CONTROL, 8'h04, "pwrt_block");
    @(posedge clock) pwrt_running <= 1'b0;
    chk("flag_idle", 32'h0, 32'(write_complete_flag));
    // Array write, with gate cleared and registers poked while busy
    bus_wr(OFF_EE_ADDR, 8'hFF);
    bus_wr(OFF_EE_DATA, 8'h3C);
    unlock();
    bus_wr(OFF_CONTROL, 8'h06);
    t0 = $time;
    bus_wr(OFF_CONTROL, 8'h00);
    bus_wr(OFF_EE_DATA, 8'h11);
    bus_wr(OFF_EE_ADDR, 8'h01);
    rchk(OFF_CONTROL, 8'h02, "busy_wr_bit");
    n = 0;
    while (write_complete_flag !== 1'b1 && n < 1000) begin
      @(posedge clock);
      #1 n++;
    end
    n = int'(($time - t0) / 10);
    chk("ee_time", 32'h1, 32'(n >= EE_ERASE_CYCLES + EE_PROG_CYCLES && n <= EE_ERASE_CYCLES + EE_PROG_CYCLES + 4));
    rchk(OFF_CONTROL, 8'h00, "wr_done");
    rchk(OFF_EE_ADDR, 8'hFF, "addr_kept");
    bus_wr(OFF_CONTROL, 8'h01);
    rchk(OFF_EE_DATA, 8'h3C, "ee_readback");
    rchk(OFF_FLAGS, 8'h01, "flag_set");
    bus_wr(OFF_FLAGS, 8'h01);
    rchk(OFF_FLAGS, 8'h01, "flag_keep");
    bus_wr(OFF_FLAGS, 8'h00);
    rchk(OFF_FLAGS, 8'h00, "flag_clear");
    // Flash row erase
    bus_wr(OFF_CONTROL, 8'h94);
    unlock();
    bus_wr(OFF_CONTROL, 8'h96);
    t0 = $time;
    n = 0;
    while (cpu_stall !== 1'b1 && n < 50) begin
      @(posedge clock);
      #1 n++;
    end
    chk("flash_erase", 32'h1, 32'(flash_cmd.erase));
    chk("flash_addr", 32'({6'h2A, 8'hC3, 8'h40}), 32'(flash_cmd.addr));
    chk("flash_prog", 32'h0, 32'(flash_cmd.prog));
    n = 0;
    while (cpu_stall === 1'b1 && n < 1000) begin
      @(posedge clock);
      #1 n++;
    end
    // Counted from the start edge, since the first wait already ate one stall cycle
    n = int'(($time - t0) / 10);
    chk("stall_len", 32'(FOC), 32'(n));
    rchk(OFF_CONTROL, 8'h84, "row_erase_done");
    rchk(OFF_FLAGS, 8'h01, "flash_flag");
    // Config space, row erase clear: a plain program command
    bus_wr(OFF_CONTROL, 8'h44);
    unlock();
    bus_wr(OFF_CONTROL, 8'h46);
    @(posedge clock);
    #1 chk("cfg_cmd", 32'h3, 32'({flash_cmd.erase, flash_cmd.prog, flash_cmd.cfg}));
    chk("cfg_stall", 32'h1, 32'(cpu_stall));
    repeat (FOC) @(posedge clock);
    #1 chk("cmd_clear", 32'h0, 32'(flash_cmd));
    chk("stall_off", 32'h0, 32'(cpu_stall));
    rchk(OFF_CONTROL, 8'h44, "cfg_done");
    // Pin reset in mid-write must leave a trace
    bus_wr(OFF_CONTROL, 8'h14);
    bus_wr(OFF_EE_ADDR, 8'h20);
    bus_wr(OFF_EE_DATA, 8'h99);
    unlock();
    bus_wr(OFF_CONTROL, 8'h16);
    repeat (20) @(posedge clock);
    do_reset(CAUSE_EXT_PIN);
    rchk(OFF_CONTROL, 8'h18, "abort_kept");
    rchk(OFF_EE_ADDR, 8'h00, "addr_reset");
    rchk(OFF_EE_DATA, 8'h00, "data_reset");
    do_reset(CAUSE_POWER_ON);
    rchk(OFF_CONTROL, 8'h00, "por_clear");
    close_out();
  end
endmodule
